/* File: rtl/tx_status_ctrl.sv */
// Transmit command parsing, status FIFO, error flag and halt control.
// Assumes the data FIFO and MAC framing sit outside; inputs synchronous.
`timescale 1ns/1ps
`include "tx_status_defines.svh"

module tx_status_ctrl
#(
	parameter int STAT_DEPTH  = 16,
	parameter int DEFER_LIMIT = `DEFER_CYCLES
)
(
	input  wire logic                   core_clk,
	input  wire logic                   rst_n,
	input  wire logic                   host_wr_valid,
	input  wire logic [31:0]            host_wr_data,
	input  wire logic                   data_fifo_full,
	output logic                        fifo_wr_valid,
	output logic [31:0]                 fifo_wr_data,
	input  wire logic                   frame_pending,
	input  wire logic [15:0]            frame_tag,
	input  wire tx_status_pkg::mac_event_t mac_event,
	output logic                        tx_go,
	output logic                        mac_abort,
	input  wire logic                   defer_check_enable,
	input  wire logic                   status_discard_overrun_enable,
	input  wire logic                   host_stat_rd,
	output logic [31:0]                 stat_rd_data,
	output logic                        stat_rd_valid,
	output logic [$clog2(STAT_DEPTH):0] status_used_count,
	input  wire logic                   status_purge,
	output logic                        tx_status_event,
	output logic                        transmitter_error_flag,
	input  wire logic                   error_clear,
	input  wire logic                   halt_set,
	input  wire logic                   tx_on_set,
	output logic                        tx_on,
	output logic                        halt_req,
	output logic                        transmit_halted_interrupt
);
	localparam int AW = $clog2(STAT_DEPTH);
	localparam int DW = $clog2(DEFER_LIMIT + 1);
	localparam logic [AW:0] FULL_CNT = (AW + 1)'(STAT_DEPTH);

	// Command parsing toward the data FIFO
	tx_status_pkg::parse_state_t parse_reg;
	logic [10:0] size_reg;
	logic [2:0]  skip_reg;
	logic [10:0] keep_reg;
	logic [10:0] total_reg;
	logic [10:0] idx_reg;
	logic        ls_reg;
	logic        fs_reg;
	logic [31:0] pkt_b_reg;
	logic [11:0] byte_acc_reg;

	wire         wr_ok = host_wr_valid && !data_fifo_full;
	wire [10:0]  a_size = host_wr_data[`CMDA_SIZE_MSB:`CMDA_SIZE_LSB];
	wire [4:0]   a_off = host_wr_data[`CMDA_OFF_MSB:`CMDA_OFF_LSB];
	wire [1:0]   a_align = host_wr_data[`CMDA_ALIGN_MSB:`CMDA_ALIGN_LSB];
	wire [12:0]  a_mask = (a_align == `ALIGN_32) ? `MASK_32 :
		(a_align == `ALIGN_16) ? `MASK_16 : `MASK_4;
	wire [12:0]  a_span = {8'h00, a_off} + {2'h0, a_size};
	wire [12:0]  a_round = (a_span + a_mask) & ~a_mask;
	wire [12:0]  a_keep = {11'h000, a_off[1:0]} + {2'h0, a_size} + 13'h0003;
	wire [10:0]  d_keep_end = {8'h00, skip_reg} + keep_reg;
	// Only offset-remainder, payload and padding-remainder DWORDs pass
	wire         d_pass = (idx_reg >= {8'h00, skip_reg})
		&& (idx_reg < d_keep_end); // R15 R16
	wire         d_last = (idx_reg + 11'h001) == total_reg;
	wire [11:0]  pkt_bytes = byte_acc_reg + {1'b0, size_reg};
	wire         len_bad = pkt_bytes !=
		{1'b0, pkt_b_reg[`CMDB_LEN_MSB:`CMDB_LEN_LSB]}; // R24
	wire         b_bad = wr_ok && parse_reg == tx_status_pkg::PARSE_B
		&& !fs_reg && host_wr_data != pkt_b_reg; // R19
	wire         end_buf = wr_ok && ((parse_reg == tx_status_pkg::PARSE_D
		&& d_last) || (parse_reg == tx_status_pkg::PARSE_B
		&& total_reg == 11'h000));
	wire         len_err = end_buf && ls_reg && len_bad; // R18

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			parse_reg <= tx_status_pkg::PARSE_A;
			size_reg <= 11'h000;
			skip_reg <= 3'h0;
			keep_reg <= 11'h000;
			total_reg <= 11'h000;
			idx_reg <= 11'h000;
			ls_reg <= 1'b0;
			fs_reg <= 1'b0;
			pkt_b_reg <= 32'h00000000;
			byte_acc_reg <= 12'h000;
			fifo_wr_valid <= 1'b0;
			fifo_wr_data <= 32'h00000000;
		end
		else
		begin
			fifo_wr_valid <= 1'b0;
			fifo_wr_data <= host_wr_data;
			if (wr_ok)
			begin
				case (parse_reg)
				tx_status_pkg::PARSE_A:
				begin
					size_reg <= a_size;
					skip_reg <= a_off[4:2];
					keep_reg <= a_keep[12:2];
					total_reg <= a_round[12:2];
					fs_reg <= host_wr_data[`CMDA_FS_BIT];
					ls_reg <= host_wr_data[`CMDA_LS_BIT];
					fifo_wr_valid <= 1'b1; // R13
					parse_reg <= tx_status_pkg::PARSE_B;
				end
				tx_status_pkg::PARSE_B:
				begin
					fifo_wr_valid <= fs_reg; // R14
					if (fs_reg)
					begin
						pkt_b_reg <= host_wr_data;
						byte_acc_reg <= 12'h000;
					end
					idx_reg <= 11'h000;
					parse_reg <= (total_reg == 11'h000) ?
						tx_status_pkg::PARSE_A : tx_status_pkg::PARSE_D;
				end
				default:
				begin
					fifo_wr_valid <= d_pass;
					idx_reg <= idx_reg + 11'h001;
					if (d_last)
						parse_reg <= tx_status_pkg::PARSE_A;
				end
				endcase
				if (end_buf)
					byte_acc_reg <= pkt_bytes;
			end
		end
	end

	// Status FIFO, oldest word at rd_ptr
	logic [31:0] stat_mem [STAT_DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0]   count_reg;
	logic          overrun_reg;

	tx_status_pkg::tx_state_t tx_reg;
	logic [4:0]    coll_reg;
	logic [DW-1:0] defer_reg;
	logic          defer_seen_reg;
	logic          lost_reg;
	logic          nocar_reg;
	logic          late_reg;
	logic          excoll_reg;
	logic          excdef_reg;
	logic [15:0]   tag_reg;

	wire fifo_full = count_reg == FULL_CNT;
	wire rd_ok = host_stat_rd && count_reg != '0; // R25
	wire stat_push = tx_reg == tx_status_pkg::TX_STAT;
	// A full FIFO in discard mode swallows the word instead of erroring
	wire stat_drop = stat_push && (overrun_reg || fifo_full); // R4
	wire stat_wr = stat_push && !stat_drop; // R1
	wire stat_ovf = stat_push && fifo_full
		&& !status_discard_overrun_enable; // R20
	wire can_start = !fifo_full || status_discard_overrun_enable; // R2 R3
	wire launch = tx_reg == tx_status_pkg::TX_IDLE && tx_on && !halt_req
		&& frame_pending && can_start; // R23
	wire halting = halt_req && tx_reg == tx_status_pkg::TX_IDLE; // R21
	wire coll_limit = mac_event.collision
		&& (coll_reg + 5'h01) == `MAX_COLLISIONS; // R10
	wire defer_limit = defer_check_enable && mac_event.deferring
		&& defer_reg == DW'(DEFER_LIMIT); // R12
	wire abort_now = tx_reg == tx_status_pkg::TX_SEND && (coll_limit
		|| mac_event.late_collision || defer_limit); // R9

	tx_status_pkg::tx_status_t stat_word;
	assign stat_word.tag = tag_reg; // R6
	assign stat_word.error_summary = lost_reg | nocar_reg | late_reg
		| excoll_reg | excdef_reg | stat_word.rsvd_1; // R7
	assign stat_word.rsvd_14_12 = 3'h0;
	assign stat_word.lost_carrier = lost_reg; // R8
	assign stat_word.no_carrier = nocar_reg; // R8
	assign stat_word.late_collision = late_reg; // R9
	assign stat_word.excess_collision = excoll_reg; // R10
	assign stat_word.rsvd_7 = 1'b0;
	assign stat_word.collision_count = coll_reg[3:0]; // R11
	assign stat_word.excess_deferral = excdef_reg; // R12
	assign stat_word.rsvd_1 = 1'b0;
	assign stat_word.deferred = defer_seen_reg; // R12

	always_ff @(posedge core_clk)
	begin
		if (stat_wr)
			stat_mem[wr_ptr_reg] <= stat_word;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n || status_purge)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			overrun_reg <= 1'b0;
		end
		else
		begin
			wr_ptr_reg <= wr_ptr_reg + AW'(stat_wr);
			rd_ptr_reg <= rd_ptr_reg + AW'(rd_ok);
			count_reg <= count_reg + (AW + 1)'(stat_wr)
				- (AW + 1)'(rd_ok);
			// A host read reopens the FIFO; an overrun in that same cycle wins
			overrun_reg <= (stat_drop && status_discard_overrun_enable)
				|| (overrun_reg && !rd_ok); // R4
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			stat_rd_data <= 32'h00000000;
			stat_rd_valid <= 1'b0;
			status_used_count <= '0;
		end
		else
		begin
			stat_rd_valid <= rd_ok;
			if (rd_ok)
				stat_rd_data <= stat_mem[rd_ptr_reg]; // R25
			status_used_count <= overrun_reg ? '0 : count_reg; // R4
		end
	end

	// Frame sequencing and per-frame status capture
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			tx_reg <= tx_status_pkg::TX_IDLE;
			coll_reg <= 5'h00;
			defer_reg <= '0;
			defer_seen_reg <= 1'b0;
			lost_reg <= 1'b0;
			nocar_reg <= 1'b0;
			late_reg <= 1'b0;
			excoll_reg <= 1'b0;
			excdef_reg <= 1'b0;
			tag_reg <= 16'h0000;
			tx_go <= 1'b0;
			mac_abort <= 1'b0;
			tx_status_event <= 1'b0;
		end
		else
		begin
			tx_go <= launch;
			mac_abort <= abort_now;
			tx_status_event <= stat_push; // R5
			case (tx_reg)
			tx_status_pkg::TX_IDLE:
			begin
				if (launch)
				begin
					tx_reg <= tx_status_pkg::TX_SEND;
					tag_reg <= frame_tag;
					coll_reg <= 5'h00;
					defer_reg <= '0;
					defer_seen_reg <= 1'b0;
					lost_reg <= 1'b0;
					nocar_reg <= 1'b0;
					late_reg <= 1'b0;
					excoll_reg <= 1'b0;
					excdef_reg <= 1'b0;
				end
			end
			tx_status_pkg::TX_SEND:
			begin
				if (mac_event.collision)
					coll_reg <= coll_reg + 5'h01; // R11
				if (mac_event.deferring)
				begin
					defer_seen_reg <= 1'b1;
					defer_reg <= defer_reg + DW'(1);
				end
				lost_reg <= lost_reg | mac_event.carrier_lost;
				nocar_reg <= nocar_reg | mac_event.no_carrier;
				late_reg <= late_reg | mac_event.late_collision;
				excoll_reg <= excoll_reg | coll_limit;
				excdef_reg <= excdef_reg | defer_limit;
				if (mac_event.frame_end || abort_now)
					tx_reg <= tx_status_pkg::TX_STAT;
			end
			default:
				tx_reg <= tx_status_pkg::TX_IDLE;
			endcase
		end
	end

	// Error flag is status only; nothing here stops on it
	wire err_event = (host_wr_valid && data_fifo_full) || stat_ovf
		|| b_bad || len_err; // R17 R20

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			transmitter_error_flag <= 1'b0;
			tx_on <= 1'b0;
			halt_req <= 1'b0;
			transmit_halted_interrupt <= 1'b0;
		end
		else
		begin
			transmitter_error_flag <= err_event
				|| (transmitter_error_flag && !error_clear);
			// Sets win over the halt-time clear so no request is lost
			tx_on <= tx_on_set || (tx_on && !halting); // R22
			halt_req <= halt_set || (halt_req && !halting); // R21 R22
			transmit_halted_interrupt <= halting; // R22
		end
	end

endmodule

/* File: rtl/tx_status_defines.svh */
// Field positions, encodings and timing constants for the transmit
// status and control block. Assumes a 200 MHz core clock.
//
// Contract
// R1: One status word pushed per finished packet
// R2: Without discard mode, full status FIFO stalls transmit
// R3: Discard mode keeps transmitting with full FIFO
// R4: Discard overrun: no error, count zero, writes stop
// R5: Status event keeps pulsing in discard mode
// R6: Status upper half carries the packet tag
// R7: Bit 15 ORs carrier, collision, deferral, bit 1
// R8: Bits 11, 10 report lost and absent carrier
// R9: Bit 9 flags late-collision abort
// R10: Abort after 16 collisions, set bit 8
// R11: Bits 6:3 hold collision count
// R12: Abort excessive deferral when enabled; bit 0 deferred
// R13: First command word always stored
// R14: Second command word stored only on first segment
// R15: Whole offset DWORDs stripped, remainder stored
// R16: Whole padding DWORDs stripped, remainder stored
// R17: Error flag never halts the transmitter
// R18: Error on byte count versus length mismatch
// R19: Both words per buffer; second-word mismatch errors
// R20: Error on data or status FIFO overrun
// R21: Halt request waits for frame in progress
// R22: After status, clear halt and on, pulse interrupt
// R23: Restart sends unpurged pending frames first
// R24: Length field bits 10:0 excludes offset, padding
// R25: Status read returns and removes oldest word
`ifndef TX_STATUS_DEFINES_SVH
`define TX_STATUS_DEFINES_SVH

`define CMDA_SIZE_MSB   10
`define CMDA_SIZE_LSB   0
`define CMDA_LS_BIT     12
`define CMDA_FS_BIT     13
`define CMDA_OFF_MSB    20
`define CMDA_OFF_LSB    16
`define CMDA_ALIGN_MSB  25
`define CMDA_ALIGN_LSB  24
`define CMDB_LEN_MSB    10
`define CMDB_LEN_LSB    0
`define CMDB_TAG_MSB    31
`define CMDB_TAG_LSB    16

`define ALIGN_4         2'h0
`define ALIGN_16        2'h1
`define ALIGN_32        2'h2
`define MASK_4          13'h0003
`define MASK_16         13'h000f
`define MASK_32         13'h001f

`define MAX_COLLISIONS  5'h10
`define EXC_DEFER_BITS  24288
`define BIT_TIME_NS     10
`define CLK_PERIOD_NS   5
`define DEFER_CYCLES    (`EXC_DEFER_BITS * `BIT_TIME_NS / `CLK_PERIOD_NS)

`endif

/* File: rtl/tx_status_pkg.sv */
// Types shared by the transmit status and control block.
// Assumes tx_status_defines.svh supplies the field constants.
package tx_status_pkg;

	typedef struct packed {
		logic [15:0] tag;
		logic        error_summary;
		logic [2:0]  rsvd_14_12;
		logic        lost_carrier;
		logic        no_carrier;
		logic        late_collision;
		logic        excess_collision;
		logic        rsvd_7;
		logic [3:0]  collision_count;
		logic        excess_deferral;
		logic        rsvd_1;
		logic        deferred;
	} tx_status_t;

	typedef struct packed {
		logic collision;
		logic late_collision;
		logic carrier_lost;
		logic no_carrier;
		logic deferring;
		logic frame_end;
	} mac_event_t;

	typedef enum logic [1:0] {
		PARSE_A = 2'b00,
		PARSE_B = 2'b01,
		PARSE_D = 2'b10
	} parse_state_t;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_SEND = 2'b01,
		TX_STAT = 2'b10
	} tx_state_t;

endpackage

/* File: tb/mac_model.sv */
// Behavioural MAC answering each launch with deferral and collisions.
// Assumes the bench sets counts and flags before the launch.
`timescale 1ns/1ps

module mac_model
(
	input wire logic                  core_clk,
	input wire logic                  tx_go,
	input wire logic                  mac_abort,
	input wire logic [4:0]            n_coll,
	input wire logic [5:0]            n_dfr,
	input wire logic [2:0]            n_flg,
	output tx_status_pkg::mac_event_t mac_event
);
	logic ab;

	initial mac_event = '0;
	always @(posedge core_clk)
	begin
		if (tx_go === 1'b1)
		begin
			ab = 1'b0;
			for (int k = 0; k < n_dfr + 2 * n_coll + 2 && !ab; k++)
			begin
				#1;
				// Stop at once on abort, as a real MAC would
				ab = ab | (mac_abort === 1'b1);
				mac_event.deferring = !ab && k < n_dfr;
				mac_event.collision = !ab && k >= n_dfr &&
					k < n_dfr + 2 * n_coll && (k - n_dfr) % 2 == 0;
				mac_event.late_collision = !ab && n_flg[2]
					&& k == n_dfr;
				mac_event.carrier_lost = !ab && n_flg[1];
				mac_event.no_carrier = !ab && n_flg[0];
				@(posedge core_clk);
			end
			#1;
			ab = ab | (mac_abort === 1'b1);
			mac_event = '0;
			// An aborted frame has no end marker; free for the next launch
			if (!ab)
			begin
				mac_event.frame_end = 1'b1;
				@(posedge core_clk);
				#1 mac_event = '0;
			end
		end
	end
endmodule

/* File: tb/tx_status_ctrl_bench.sv */
// Self-checking bench for the transmit status and control block.
// Assumes the MAC model answers launches; deferral limit shortened.
`timescale 1ns/1ps

module tx_status_ctrl_bench;
	localparam int DLIM = 20;
	typedef struct packed
	{
		logic [2:0]  f;
		logic [4:0]  c;
		logic [5:0]  d;
		logic [15:0] lo;
		logic [15:0] m;
	} row_t;
	// Bits 6:3 are masked where excessive collisions leave them undefined
	row_t rows [8] = '{'{3'h0, 5'h00, 6'h00, 16'h0000, 16'hffff},
		'{3'h0, 5'h03, 6'h00, 16'h0018, 16'hffff},
		'{3'h0, 5'h0f, 6'h00, 16'h0078, 16'hffff},
		'{3'h0, 5'h10, 6'h00, 16'h8100, 16'hff87},
		'{3'h0, 5'h00, 6'h03, 16'h0001, 16'hffff},
		'{3'h0, 5'h00, 6'h19, 16'h8005, 16'hffff},
		'{3'h4, 5'h00, 6'h00, 16'h8200, 16'hffff},
		'{3'h3, 5'h00, 6'h00, 16'h8c00, 16'hffff}};
	// Last four buffers form two packets of a first and a last segment
	logic [31:0] ca [7] = '{32'h00053006, 32'h01003006, 32'h00003006,
		32'h00002004, 32'h00001002, 32'h00002004, 32'h00001002};
	logic [31:0] cb [7] = '{32'h00aa0006, 32'h00aa0006, 32'h00aa0007,
		32'h00aa0006, 32'h00aa0006, 32'h00aa0006, 32'h00bb0006};
	int          nd [7] = '{3, 4, 2, 1, 1, 1, 1};
	int          nw [7] = '{4, 4, 4, 3, 2, 3, 2};
	logic        ne [7] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
	logic core_clk = 1'b0, rst_n = 1'b0, host_wr_valid = 1'b0;
	logic data_fifo_full = 1'b0, frame_pending = 1'b0, disc_en = 1'b0;
	logic defer_check_enable = 1'b1, host_stat_rd = 1'b0;
	logic status_purge = 1'b0, error_clear = 1'b0, halt_set = 1'b0;
	logic tx_on_set = 1'b0;
	logic [31:0] host_wr_data = 32'h0;
	logic [15:0] frame_tag = 16'h0;
	logic [4:0]  n_coll = 5'h0;
	logic [5:0]  n_dfr = 6'h0;
	logic [2:0]  n_flg = 3'h0;
	logic fifo_wr_valid, tx_go, mac_abort, stat_rd_valid, tx_on;
	logic tx_status_event, transmitter_error_flag, halt_req;
	logic transmit_halted_interrupt;
	logic [31:0] fifo_wr_data, stat_rd_data;
	logic [4:0]  status_used_count;
	tx_status_pkg::mac_event_t mac_event;
	wire logic [2:0] evs = {tx_go, tx_status_event, transmit_halted_interrupt};
	int mismatches = 0, n_checks = 0, nwr = 0, ngo = 0, nab = 0, g;

	tx_status_ctrl #(.DEFER_LIMIT(DLIM)) dut (.core_clk, .rst_n,
		.host_wr_valid, .host_wr_data, .data_fifo_full, .fifo_wr_valid,
		.fifo_wr_data, .frame_pending, .frame_tag, .mac_event, .tx_go,
		.mac_abort, .defer_check_enable,
		.status_discard_overrun_enable(disc_en), .host_stat_rd,
		.stat_rd_data, .stat_rd_valid, .status_used_count, .status_purge,
		.tx_status_event, .transmitter_error_flag, .error_clear, .halt_set,
		.tx_on_set, .tx_on, .halt_req, .transmit_halted_interrupt);
	mac_model mac (.core_clk, .tx_go, .mac_abort, .n_coll, .n_dfr,
		.n_flg, .mac_event);

	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		nwr += fifo_wr_valid === 1'b1;
		ngo += tx_go === 1'b1;
		nab += mac_abort === 1'b1;
	end

	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tick(int n = 1);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wait_hi(int b, string nm);
		for (int i = 0; i < 200 && evs[b] !== 1'b1; i++)
			tick();
		chk(nm, evs[b], 1'b1);
	endtask
	task automatic launch(logic [4:0] c, logic [5:0] d, logic [15:0] t);
		n_coll = c;
		n_dfr = d;
		frame_tag = t;
		frame_pending = 1'b1;
		wait_hi(2, "tx_go");
		frame_pending = 1'b0;
	endtask
	task automatic rd(logic [31:0] exp, logic [31:0] msk);
		host_stat_rd = 1'b1;
		tick();
		host_stat_rd = 1'b0;
		chk("stat valid", stat_rd_valid, 1'b1);
		chk("stat word", stat_rd_data & msk, exp);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		#100000;
		mismatches++;
		test_done();
	end

	initial
	begin
		tick(20);
		rst_n = 1'b1;
		chk("tx_on at reset", tx_on, 1'b0);
		tx_on_set = 1'b1;
		tick();
		tx_on_set = 1'b0;
		foreach (rows[i])
		begin
			n_flg = rows[i].f;
			launch(rows[i].c, rows[i].d, 16'h00a0 + 16'(i));
			wait_hi(1, "status event");
			rd({16'h00a0 + 16'(i), rows[i].lo}, {16'hffff, rows[i].m});
		end
		n_flg = 3'h0;
		chk("aborts", nab, 32'h3);
		defer_check_enable = 1'b0;
		launch(5'h00, 6'h19, 16'h00e0);
		wait_hi(1, "status event");
		rd(32'h00e00001, 32'hffffffff);
		chk("no defer abort", nab, 32'h3);
		defer_check_enable = 1'b1;
		// Offset, padding, segment and length mismatch cases
		for (int j = 0; j < 7; j++)
		begin
			error_clear = 1'b1;
			tick();
			error_clear = 1'b0;
			nwr = 0;
			for (int k = 0; k < 2 + nd[j]; k++)
			begin
				host_wr_valid = 1'b1;
				host_wr_data = k == 0 ? ca[j] : k == 1 ? cb[j] : k;
				tick();
			end
			host_wr_valid = 1'b0;
			tick(3);
			chk("stored words", nwr, nw[j]);
			chk("error flag", transmitter_error_flag, ne[j]);
		end
		launch(5'h03, 6'h00, 16'h00b0);
		halt_set = 1'b1;
		tick();
		halt_set = 1'b0;
		chk("on while frame runs", tx_on, 1'b1);
		wait_hi(0, "halted interrupt");
		chk("on cleared", tx_on | halt_req, 1'b0);
		rd(32'h00b00018, 32'hffffffff);
		frame_pending = 1'b1;
		g = ngo;
		tick(8);
		chk("no launch halted", ngo - g, 32'h0);
		tx_on_set = 1'b1;
		tick();
		tx_on_set = 1'b0;
		launch(5'h00, 6'h00, 16'h00c0);
		wait_hi(1, "status event");
		rd(32'h00c00000, 32'hffffffff);
		error_clear = 1'b1;
		tick();
		error_clear = 1'b0;
		for (int k = 0; k < 16; k++)
		begin
			launch(5'h00, 6'h00, 16'(k));
			wait_hi(1, "status event");
		end
		frame_pending = 1'b1;
		g = ngo;
		tick(10);
		chk("stall on full", ngo - g, 32'h0);
		disc_en = 1'b1;
		launch(5'h00, 6'h00, 16'h00d0);
		wait_hi(1, "status event");
		tick(3);
		chk("count on overrun", status_used_count, 5'h0);
		chk("no overrun error", transmitter_error_flag, 1'b0);
		rd(32'h00000000, 32'hffffffff);
		tick();
		chk("count after read", status_used_count, 5'hf);
		status_purge = 1'b1;
		tick();
		status_purge = 1'b0;
		tick();
		chk("count after purge", status_used_count, 5'h0);
		host_stat_rd = 1'b1;
		tick();
		host_stat_rd = 1'b0;
		chk("read on empty", stat_rd_valid, 1'b0);
		data_fifo_full = 1'b1;
		host_wr_valid = 1'b1;
		tick();
		host_wr_valid = 1'b0;
		data_fifo_full = 1'b0;
		tick();
		chk("data overrun", transmitter_error_flag, 1'b1);
		test_done();
	end
endmodule

/* File: tb/tx_status_ctrl_props.sv */
// Checker for the transmit status and control block.
// Sees only the top module ports; attached by the bind below.
`timescale 1ns/1ps

module tx_status_ctrl_props
(
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        host_wr_valid,
	input wire logic [31:0] host_wr_data,
	input wire logic        data_fifo_full,
	input wire logic        fifo_wr_valid,
	input wire logic [31:0] fifo_wr_data,
	input wire logic        frame_pending,
	input wire logic        tx_go,
	input wire logic        host_stat_rd,
	input wire logic [31:0] stat_rd_data,
	input wire logic        stat_rd_valid,
	input wire logic        transmitter_error_flag,
	input wire logic        tx_on,
	input wire logic        halt_req,
	input wire logic        transmit_halted_interrupt
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_err_summary: assert property (
		stat_rd_valid |-> stat_rd_data[15] ==
		|{stat_rd_data[11:8], stat_rd_data[2:1]})
		else $error("summary bit wrong");
	a_rsvd_zero: assert property (
		stat_rd_valid |-> stat_rd_data[14:12] == 3'h0 && !stat_rd_data[7])
		else $error("reserved status bits set");
	a_rd_cause: assert property (
		stat_rd_valid |-> $past(host_stat_rd))
		else $error("status valid without read");
	a_wr_echo: assert property (
		fifo_wr_valid |-> $past(host_wr_valid && !data_fifo_full) &&
		fifo_wr_data == $past(host_wr_data))
		else $error("stored word not from host");
	a_ovr_err: assert property (
		host_wr_valid && data_fifo_full |=> transmitter_error_flag)
		else $error("overrun left error flag low");
	a_go_gate: assert property (
		tx_go |-> $past(tx_on && !halt_req && frame_pending) ##1 !tx_go)
		else $error("launch while off or halting");
	a_halt_cause: assert property (
		transmit_halted_interrupt |-> $past(halt_req) && $past(tx_on))
		else $error("halt interrupt without request");
	a_halt_done: assert property (
		transmit_halted_interrupt |-> !tx_on && !halt_req
		##1 !transmit_halted_interrupt)
		else $error("halt did not clear or pulse");
endmodule

bind tx_status_ctrl tx_status_ctrl_props chk (.core_clk, .rst_n,
	.host_wr_valid, .host_wr_data, .data_fifo_full, .fifo_wr_valid,
	.fifo_wr_data, .frame_pending, .tx_go, .host_stat_rd,
	.stat_rd_data, .stat_rd_valid, .transmitter_error_flag, .tx_on,
	.halt_req, .transmit_halted_interrupt);
